// File: core/exc_params.svh
// constants for the exception sequencing unit: vectors, error code layout, pin idle level, mode at reset
// assumes inclusion by name from the sequencer file
`ifndef EXC_PARAMS_SVH
`define EXC_PARAMS_SVH

`define VEC_DIVIDE 8'h00
`define VEC_STEP 8'h01
`define VEC_NMI 8'h02
`define VEC_BREAK 8'h03
`define VEC_OVERFLOW 8'h04
`define VEC_BOUND 8'h05
`define VEC_BAD_OPCODE 8'h06
`define VEC_NO_COPROC 8'h07
`define VEC_DOUBLE 8'h08
`define VEC_OVERRUN 8'h09
`define VEC_BAD_TSS 8'h0a
`define VEC_NOT_PRESENT 8'h0b
`define VEC_STACK 8'h0c
`define VEC_GENERAL 8'h0d
`define VEC_COPROC_ERR 8'h10
`define VEC_RESERVED_LAST 8'h1f

`define ERR_EXT_BIT 0
`define ERR_IDT_BIT 1
`define ERR_LDT_BIT 2
`define ERR_SEL_LSB 3
`define ERR_NULL 16'h0000

`define ADDR_BIT_ONE_IDLE 1'b1
`define PROT_MODE_RESET 1'b0

`endif

// File: core/exc_pkg.sv
// types shared by the exception sequencing unit and its neighbours
// assumes exc_params.svh sits beside it
package exc_pkg;

	// cause reported by the execution unit
	typedef enum logic [3:0] {
		cause_divide = 4'h0,
		cause_break = 4'h1,
		cause_overflow = 4'h2,
		cause_bound = 4'h3,
		cause_bad_opcode = 4'h4,
		cause_bad_operand = 4'h5,
		cause_no_coproc = 4'h6,
		cause_coproc_err = 4'h7,
		cause_bad_tss = 4'h8,
		cause_not_present = 4'h9,
		cause_stack = 4'ha,
		cause_general = 4'hb
	} cause_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_invoke = 2'b01,
		st_shutdown = 2'b10,
		st_nmi_exit = 2'b11
	} state_t;

	// fault report from the execution unit
	typedef struct packed {
		logic valid;
		cause_t cause;
		logic executing;
		logic ext;
		logic has_sel;
		logic [15:0] selector;
		logic interrupt_descriptor_table;
		logic local_descriptor_table;
		logic rmw_ro;
		logic [15:0] prefix_addr;
	} exc_req_t;

	// one limit check of the coprocessor data channel
	typedef struct packed {
		logic valid;
		logic later_word;
		logic [15:0] offset;
		logic [15:0] limit;
	} cop_xfer_t;

	// handler invocation order to the frame sequencer
	typedef struct packed {
		logic valid;
		logic [7:0] vector;
		logic push_code;
		logic [15:0] code;
		logic restartable;
		logic [15:0] ret_addr;
		logic ext;
	} dispatch_t;

endpackage : exc_pkg

// File: core/exception_sequencer.sv
// exception and interrupt sequencer: picks the next handler, builds its error code,
// detects double faults and runs the shutdown state
// assumes a frame sequencer that acts on dispatch_out and reports invoke_done_in
`timescale 1ns/100ps
`include "exc_params.svh"

// Operation
// - protection violations are exceptions, never masked, via any gate kind
// - vectors 0 to 31 reserved, fixed vector per cause, 0 up to 13; the code sends coprocessor error to 16
// - simultaneous requests: exception, step, nmi, overrun, then maskable request
// - save state per request; pending enabled ones taken before handler runs
// - error code for 8, 10 to 13; none for 0 to 7 and 9
// - all restartable except overrun and carry-type writes to read-only segments; the code also marks double fault not restartable
// - saved return address points at first prefix of faulting instruction
// - error code names the selector; bits 15 to 3 zero without one
// - error code pushed after return address on the handler's stack
// - bad opcode raises 6 only on execution, no error code
// - illegal operand forms also raise vector 6
// - second fault after first of 0 or 10 to 13 gives vector 8
// - violation while handling double fault enters shutdown, nothing runs
// - nmi leaves shutdown if its service is clean, else only reset; the code lets a later nmi leave it again
// - nmi exit keeps protected mode; reset returns to real mode
// - shutdown entry shown as halt cycle with address bit one low
// - new fault while invoking 1-7, 9 or 16 gives no double fault
// - channel checks limit; later word out of segment raises 9
// - vector 9 is an asynchronous request carrying no operation identity
// - error bit 0 set for events outside the program
// - error bit 1 marks descriptor table of vectors; else bit 2 local/global
module exception_sequencer
	import exc_pkg::*;
(
	input wire logic core_clk_in, // processor clock
	input wire logic rst_in, // async reset, active high
	input wire exc_req_t exc_in, // fault report, same clock
	input wire logic step_in, // single step trap pulse, same clock
	input wire logic nmi_in, // non-maskable pin, async
	input wire logic maskable_interrupt_request_in, // request pin, async
	input wire logic maskable_interrupt_request_enable_in, // interrupt flag
	input wire logic [7:0] maskable_interrupt_request_vector_in, // vector from interrupt controller
	input wire logic [15:0] next_addr_in, // code_pointer of next instruction
	input wire logic invoke_done_in, // handler entry finished, pulse
	input wire logic prot_enable_in, // enter protected mode, pulse
	input wire cop_xfer_t cop_in, // coprocessor channel transfer
	output dispatch_t dispatch_out, // handler invocation, valid one cycle
	output logic maskable_interrupt_request_ack_out, // maskable request taken, pulse
	output logic halt_cycle_out, // halt bus cycle, pulse
	output logic address_bit_one_out, // address bit one of that cycle
	output logic shutdown_out, // in shutdown
	output logic prot_mode_out // protected mode active
);

	state_t state_ff;
	state_t nxt_state;
	logic [7:0] cur_vec_ff;
	logic cur_ext_ff;
	logic [1:0] nmi_sync_ff;
	logic [1:0] maskable_interrupt_request_sync_ff;
	logic nmi_last_ff;
	logic nmi_pend_ff;
	logic step_pend_ff;
	logic ovr_pend_ff;
	dispatch_t dispatch_ff;
	dispatch_t nxt_dispatch;
	logic maskable_interrupt_request_ack_ff;
	logic halt_ff;
	logic abit_ff;
	logic shut_ff;
	logic prot_ff;

	// cause to fixed vector
	function automatic logic [7:0] cause_vector(input cause_t c);
		logic [7:0] v;
		v = `VEC_GENERAL;
		unique case (c)
			cause_divide: v = `VEC_DIVIDE;
			cause_break: v = `VEC_BREAK;
			cause_overflow: v = `VEC_OVERFLOW;
			cause_bound: v = `VEC_BOUND;
			cause_bad_opcode: v = `VEC_BAD_OPCODE;
			cause_bad_operand: v = `VEC_BAD_OPCODE;
			cause_no_coproc: v = `VEC_NO_COPROC;
			cause_coproc_err: v = `VEC_COPROC_ERR;
			cause_bad_tss: v = `VEC_BAD_TSS;
			cause_not_present: v = `VEC_NOT_PRESENT;
			cause_stack: v = `VEC_STACK;
			cause_general: v = `VEC_GENERAL;
			// unused cause codes fold into general protection, never masked
			default: v = `VEC_GENERAL;
		endcase
		return v;
	endfunction : cause_vector

	// first faults that escalate a second one
	function automatic logic contributory(input logic [7:0] v);
		return v == `VEC_DIVIDE || (v >= `VEC_BAD_TSS && v <= `VEC_GENERAL);
	endfunction : contributory

	// vectors whose frame carries an error code
	function automatic logic has_code(input logic [7:0] v);
		return v == `VEC_DOUBLE || (v >= `VEC_BAD_TSS && v <= `VEC_GENERAL);
	endfunction : has_code

	// request decode
	wire in_idle = state_ff == st_idle;
	wire in_invoke = state_ff == st_invoke;
	wire in_shut = state_ff == st_shutdown;
	wire in_nmi_exit = state_ff == st_nmi_exit;
	// a bad opcode seen only by prefetch is dropped here
	wire exc_ok = exc_in.valid && !(exc_in.cause == cause_bad_opcode && !exc_in.executing);
	wire [7:0] exc_vec = cause_vector(exc_in.cause);
	wire maskable_interrupt_request_live = maskable_interrupt_request_sync_ff[1] && maskable_interrupt_request_enable_in;
	wire ovr_hit = cop_in.valid && cop_in.later_word && (cop_in.offset > cop_in.limit);

	// fixed priority, instruction exception never masked
	wire take_exc = in_idle && exc_ok;
	wire take_step = in_idle && !exc_ok && step_pend_ff;
	wire take_nmi_run = in_idle && !exc_ok && !step_pend_ff && nmi_pend_ff;
	wire take_nmi = take_nmi_run || (in_shut && nmi_pend_ff);
	wire take_ovr = in_idle && !exc_ok && !step_pend_ff && !nmi_pend_ff && ovr_pend_ff;
	wire take_maskable_interrupt_request = in_idle && !exc_ok && !step_pend_ff && !nmi_pend_ff && !ovr_pend_ff && maskable_interrupt_request_live;

	// faults raised while a handler is being entered
	wire go_shut = exc_ok && ((in_invoke && cur_vec_ff == `VEC_DOUBLE) || in_nmi_exit);
	wire go_double = in_invoke && exc_ok && !go_shut && contributory(cur_vec_ff);
	wire redispatch = in_invoke && exc_ok && !go_shut;
	wire exc_path = take_exc || (redispatch && !go_double);
	wire any_take = take_exc || take_step || take_nmi || take_ovr || take_maskable_interrupt_request || redispatch;

	// vector and frame selection
	wire [7:0] sel_vec = go_double ? `VEC_DOUBLE :
		exc_path ? exc_vec :
		take_step ? `VEC_STEP :
		take_nmi ? `VEC_NMI :
		take_ovr ? `VEC_OVERRUN : maskable_interrupt_request_vector_in;
	// a fault while entering an external event's handler inherits its origin
	wire sel_ext = exc_path ? (exc_in.ext || (redispatch && cur_ext_ff)) :
		go_double ? cur_ext_ff : 1'b1;
	wire [12:0] sel_field = exc_in.has_sel ? exc_in.selector[15:`ERR_SEL_LSB] : 13'h0000;
	wire sel_ldt = !exc_in.interrupt_descriptor_table && exc_in.local_descriptor_table;
	wire [15:0] sel_code = go_double ? `ERR_NULL : {sel_field, sel_ldt, exc_in.interrupt_descriptor_table, sel_ext};
	// carry-type writes to read-only segments cannot be replayed
	wire sel_restart = !(sel_vec == `VEC_OVERRUN || sel_vec == `VEC_DOUBLE ||
		(exc_path && exc_in.rmw_ro && exc_vec == `VEC_GENERAL));
	// faults point back at the first prefix, interrupts at the next instruction
	wire [15:0] sel_ret = (exc_path || go_double) ? exc_in.prefix_addr : next_addr_in;

	// invocation order; frame sequencer pushes return address, then code on handler stack
	always_comb begin
		nxt_dispatch = '0;
		nxt_dispatch.valid = any_take;
		nxt_dispatch.vector = sel_vec;
		nxt_dispatch.push_code = has_code(sel_vec) && !take_maskable_interrupt_request;
		nxt_dispatch.code = has_code(sel_vec) ? sel_code : `ERR_NULL;
		nxt_dispatch.restartable = sel_restart;
		nxt_dispatch.ret_addr = sel_ret;
		nxt_dispatch.ext = sel_ext;
	end

	// sequencing states
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			st_idle: nxt_state = any_take ? st_invoke : st_idle;
			st_invoke: begin
				if (go_shut)
					nxt_state = st_shutdown;
				else if (!exc_ok && invoke_done_in)
					nxt_state = st_idle;
			end
			st_shutdown: nxt_state = take_nmi ? st_nmi_exit : st_shutdown;
			st_nmi_exit: begin
				if (go_shut)
					nxt_state = st_shutdown;
				else if (invoke_done_in)
					nxt_state = st_idle;
			end
		endcase
	end

	// pin synchronisers, edge taken from the second stage only
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			nmi_sync_ff <= 2'h0;
			maskable_interrupt_request_sync_ff <= 2'h0;
			nmi_last_ff <= 1'b0;
		end else begin
			nmi_sync_ff <= {nmi_sync_ff[0], nmi_in};
			maskable_interrupt_request_sync_ff <= {maskable_interrupt_request_sync_ff[0], maskable_interrupt_request_in};
			nmi_last_ff <= nmi_sync_ff[1];
		end
	end

	wire nmi_rise = nmi_sync_ff[1] && !nmi_last_ff;

	// pending flags, a new event wins over its own take
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			nmi_pend_ff <= 1'b0;
			step_pend_ff <= 1'b0;
			ovr_pend_ff <= 1'b0;
		end else begin
			nmi_pend_ff <= nmi_rise || (nmi_pend_ff && !take_nmi);
			step_pend_ff <= step_in || (step_pend_ff && !take_step);
			// nothing about the coprocessor operation is kept
			ovr_pend_ff <= ovr_hit || (ovr_pend_ff && !take_ovr);
		end
	end

	// sequencer state and current handler
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff <= st_idle;
			cur_vec_ff <= 8'h00;
			cur_ext_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cur_vec_ff <= any_take ? sel_vec : cur_vec_ff;
			cur_ext_ff <= any_take ? sel_ext : cur_ext_ff;
		end
	end

	// registered outputs
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			dispatch_ff <= '0;
			maskable_interrupt_request_ack_ff <= 1'b0;
			halt_ff <= 1'b0;
			abit_ff <= `ADDR_BIT_ONE_IDLE;
			shut_ff <= 1'b0;
			prot_ff <= `PROT_MODE_RESET;
		end else begin
			dispatch_ff <= nxt_dispatch;
			maskable_interrupt_request_ack_ff <= take_maskable_interrupt_request;
			halt_ff <= go_shut;
			abit_ff <= go_shut ? 1'b0 : `ADDR_BIT_ONE_IDLE;
			shut_ff <= nxt_state == st_shutdown;
			prot_ff <= prot_ff || prot_enable_in;
		end
	end

	assign dispatch_out = dispatch_ff;
	assign maskable_interrupt_request_ack_out = maskable_interrupt_request_ack_ff;
	assign halt_cycle_out = halt_ff;
	assign address_bit_one_out = abit_ff;
	assign shutdown_out = shut_ff;
	assign prot_mode_out = prot_ff;

	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	sequence dbl_handler_fault_s;
		in_invoke && cur_vec_ff == `VEC_DOUBLE && exc_ok;
	endsequence

	sequence halt_signalled_s;
		halt_cycle_out && !address_bit_one_out && shutdown_out;
	endsequence

	reserved_vec_a: assert property (dispatch_out.valid && !$past(take_maskable_interrupt_request)
		|-> dispatch_out.vector <= `VEC_RESERVED_LAST) else $error("reserved vector out of range");
	prio_order_a: assert property (in_idle && exc_ok && (step_pend_ff || nmi_pend_ff)
		|=> dispatch_out.valid && dispatch_out.vector == $past(exc_vec)) else $error("priority order broken");
	code_push_a: assert property (dispatch_out.valid && !$past(take_maskable_interrupt_request)
		|-> dispatch_out.push_code == has_code(dispatch_out.vector)) else $error("error code push wrong");
	no_restart_a: assert property (dispatch_out.valid && dispatch_out.vector == `VEC_OVERRUN
		|-> !dispatch_out.restartable) else $error("overrun marked restartable");
	null_sel_a: assert property (take_exc && !exc_in.has_sel && has_code(exc_vec)
		|=> dispatch_out.code[15:3] == 13'h0000) else $error("selector bits not zero");
	double_fault_a: assert property (in_invoke && contributory(cur_vec_ff) && exc_ok
		&& cur_vec_ff != `VEC_DOUBLE |=> dispatch_out.valid && dispatch_out.vector == `VEC_DOUBLE
		&& dispatch_out.code == `ERR_NULL) else $error("double fault not raised");
	benign_fault_a: assert property (in_invoke && !contributory(cur_vec_ff) && exc_ok
		&& cur_vec_ff != `VEC_DOUBLE |=> dispatch_out.vector != `VEC_DOUBLE) else $error("spurious double fault");
	shut_entry_a: assert property (dbl_handler_fault_s |=> halt_signalled_s ##1 !halt_cycle_out)
		else $error("shutdown entry not signalled once");
	shut_hold_a: assert property (in_shut && !nmi_pend_ff |=> in_shut && !dispatch_out.valid)
		else $error("shutdown left without nmi");
	nmi_exit_a: assert property (in_nmi_exit && invoke_done_in && !exc_ok
		|=> in_idle && !shutdown_out && $stable(prot_mode_out)) else $error("nmi exit wrong");
	prefetch_opc_a: assert property (in_idle && exc_in.valid && exc_in.cause == cause_bad_opcode
		&& !exc_in.executing && !step_pend_ff && !nmi_pend_ff && !ovr_pend_ff && !maskable_interrupt_request_live
		|=> !dispatch_out.valid) else $error("prefetched opcode faulted");
	overrun_a: assert property (ovr_hit |=> ovr_pend_ff) else $error("overrun lost");

	// maskable acknowledge rides on its own dispatch and never carries a code
	maskable_interrupt_request_ack_a: assert property (maskable_interrupt_request_ack_out
		|-> dispatch_out.valid && !dispatch_out.push_code) else $error("acknowledge without dispatch");

	// halt indication and address bit one move together, once per entry
	halt_abit_a: assert property (halt_cycle_out |-> !address_bit_one_out)
		else $error("halt cycle with address bit one high");
	abit_idle_a: assert property (!halt_cycle_out |-> address_bit_one_out)
		else $error("address bit one low outside halt");
	halt_once_a: assert property (halt_cycle_out |=> !halt_cycle_out)
		else $error("halt indication repeated");

	// only reset leaves protected mode
	prot_sticky_a: assert property (prot_mode_out |=> prot_mode_out)
		else $error("protected mode dropped without reset");

	// double fault frame: null code pushed, never restartable
	double_frame_a: assert property (dispatch_out.valid && dispatch_out.vector == `VEC_DOUBLE
		&& !$past(take_maskable_interrupt_request) |-> dispatch_out.push_code && !dispatch_out.restartable
		&& dispatch_out.code == `ERR_NULL) else $error("double fault frame wrong");

	// external events carry the outside-origin mark and no code
	step_take_a: assert property (take_step
		|=> dispatch_out.vector == `VEC_STEP && dispatch_out.ext && !dispatch_out.push_code)
		else $error("step dispatch wrong");
	nmi_take_a: assert property (take_nmi
		|=> dispatch_out.valid && dispatch_out.vector == `VEC_NMI && dispatch_out.ext
		&& !dispatch_out.push_code) else $error("nmi dispatch wrong");
	ovr_take_a: assert property (take_ovr
		|=> dispatch_out.vector == `VEC_OVERRUN && !dispatch_out.restartable
		&& !dispatch_out.push_code) else $error("overrun dispatch wrong");

	// a fault taken from idle returns to its first prefix
	fault_ret_a: assert property (take_exc
		|=> dispatch_out.ret_addr == $past(exc_in.prefix_addr)) else $error("fault return address wrong");

	// error code origin and table bits follow the report
	code_ext_a: assert property (take_exc && has_code(exc_vec)
		|=> dispatch_out.code[`ERR_EXT_BIT] == $past(exc_in.ext)) else $error("origin bit wrong");
	code_table_a: assert property (take_exc && has_code(exc_vec)
		|=> !(dispatch_out.code[`ERR_IDT_BIT] && dispatch_out.code[`ERR_LDT_BIT]))
		else $error("local table bit set with vector table");

	// shutdown flag mirrors the state and nothing is serviced there
	shut_flag_a: assert property (shutdown_out == in_shut)
		else $error("shutdown flag disagrees with state");
	shut_quiet_a: assert property (in_shut
		|-> !maskable_interrupt_request_ack_out && !dispatch_out.valid) else $error("service inside shutdown");

endmodule : exception_sequencer

// File: bench/ext_sources_model.sv
// model of the interrupt pins and the coprocessor data channel
// assumes commands from the bench, changed at the falling clock edge
`timescale 1ns/100ps
module ext_sources_model
	import exc_pkg::*;
(
	input wire logic core_clk_in, // processor clock
	input wire logic nmi_cmd_in, // request one nmi edge
	input wire logic irq_cmd_in, // hold the request pin
	input wire logic [7:0] vec_cmd_in, // vector to hand over
	input wire cop_xfer_t xfer_cmd_in, // transfer to check
	output logic nmi_out, // nmi pin
	output logic irq_out, // request pin
	output logic [7:0] vec_out, // vector lines
	output cop_xfer_t cop_out, // channel transfer
	output logic busy_out // coprocessor busy
);
	logic [2:0] nmi_cnt_ff = 3'h0;
	logic busy_ff = 1'b0;

	// nmi held four cycles so the synchroniser sees a clean edge
	always_ff @(posedge core_clk_in) begin
		if (nmi_cmd_in) begin
			nmi_cnt_ff <= 3'h4;
		end else if (nmi_cnt_ff != 3'h0) begin
			nmi_cnt_ff <= nmi_cnt_ff - 3'h1;
		end
	end

	// a word beyond the limit leaves the coprocessor waiting on data until the next transfer
	always_ff @(posedge core_clk_in) begin
		if (xfer_cmd_in.valid) begin
			busy_ff <= xfer_cmd_in.offset > xfer_cmd_in.limit;
		end
	end

	// released vector and channel lines show the inverse, never a stale copy
	assign nmi_out = nmi_cnt_ff != 3'h0;
	assign irq_out = irq_cmd_in;
	assign vec_out = irq_cmd_in ? vec_cmd_in : ~vec_cmd_in;
	assign cop_out = xfer_cmd_in.valid ? xfer_cmd_in : {1'b0, ~xfer_cmd_in[32:0]};
	assign busy_out = busy_ff;
endmodule : ext_sources_model

// File: bench/tb_exception_sequencer.sv
// self-checking bench of the exception sequencer
// assumes the pin and coprocessor model beside it; no vector 9 handler reissues waits
`timescale 1ns/100ps
module tb_exception_sequencer
	import exc_pkg::*;
;
	logic core_clk_in = 1'b0, rst_in = 1'b1, step_in = 1'b0, ien = 1'b0, done = 1'b0, pen = 1'b0;
	logic nmi_cmd = 1'b0, irq_cmd = 1'b0, nmi, irq, ack, halt, abo, shut, prot;
	logic [7:0] vcmd = 8'h40, vec;
	exc_req_t exc_in;
	cop_xfer_t xfer = '0, cop;
	dispatch_t dsp;
	int checked = 0, failures = 0;

	ext_sources_model i_ext_sources_model (.core_clk_in(core_clk_in), .nmi_cmd_in(nmi_cmd),
		.irq_cmd_in(irq_cmd), .vec_cmd_in(vcmd), .xfer_cmd_in(xfer), .nmi_out(nmi),
		.irq_out(irq), .vec_out(vec), .cop_out(cop), .busy_out());
	exception_sequencer i_exception_sequencer (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.exc_in(exc_in), .step_in(step_in), .nmi_in(nmi), .maskable_interrupt_request_in(irq),
		.maskable_interrupt_request_enable_in(ien), .maskable_interrupt_request_vector_in(vec), .next_addr_in(16'h4000), .invoke_done_in(done),
		.prot_enable_in(pen), .cop_in(cop), .dispatch_out(dsp), .maskable_interrupt_request_ack_out(ack),
		.halt_cycle_out(halt), .address_bit_one_out(abo), .shutdown_out(shut), .prot_mode_out(prot));

	// 50 MHz clock
	always #10 core_clk_in = ~core_clk_in;

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task print_verdict;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	// bounded wait for the next dispatch pulse
	task wait_dsp(input int lim);
		int i;
		i = 0;
		while (dsp.valid !== 1'b1 && i < lim) begin
			@(negedge core_clk_in);
			i++;
		end
	endtask : wait_dsp

	task done_pulse;
		@(negedge core_clk_in);
		done = 1'b1;
		@(negedge core_clk_in);
		done = 1'b0;
	endtask : done_pulse

	task set_exc(input cause_t c, input logic sel, input logic rmw);
		exc_in.cause = c;
		exc_in.has_sel = sel;
		exc_in.rmw_ro = rmw;
		exc_in.executing = 1'b1;
		exc_in.valid = 1'b1;
	endtask : set_exc

	// one fault from idle; selector bits kept, low bits local table
	task fault(input cause_t c, input logic sel, input logic rmw, input logic [7:0] ev, input logic ep,
		input logic er);
		@(negedge core_clk_in);
		set_exc(c, sel, rmw);
		@(negedge core_clk_in);
		exc_in.valid = 1'b0;
		wait_dsp(8);
		chk(dsp.vector, ev);
		chk(dsp.push_code, ep);
		if (ep)
			chk(dsp.code, sel ? 16'hbeec : 16'h0004);
		chk(dsp.restartable, er);
		chk(dsp.ret_addr, 16'h1230);
		done_pulse;
	endtask : fault

	task t_table;
		fault(cause_divide, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
		fault(cause_break, 1'b0, 1'b0, 8'h03, 1'b0, 1'b1);
		fault(cause_overflow, 1'b0, 1'b0, 8'h04, 1'b0, 1'b1);
		fault(cause_bound, 1'b0, 1'b0, 8'h05, 1'b0, 1'b1);
		fault(cause_bad_opcode, 1'b0, 1'b0, 8'h06, 1'b0, 1'b1);
		fault(cause_bad_operand, 1'b0, 1'b0, 8'h06, 1'b0, 1'b1);
		fault(cause_no_coproc, 1'b0, 1'b0, 8'h07, 1'b0, 1'b1);
		fault(cause_coproc_err, 1'b0, 1'b0, 8'h10, 1'b0, 1'b1);
		fault(cause_bad_tss, 1'b1, 1'b0, 8'h0a, 1'b1, 1'b1);
		fault(cause_not_present, 1'b1, 1'b0, 8'h0b, 1'b1, 1'b1);
		fault(cause_stack, 1'b0, 1'b0, 8'h0c, 1'b1, 1'b1);
		fault(cause_general, 1'b1, 1'b0, 8'h0d, 1'b1, 1'b1);
		fault(cause_general, 1'b1, 1'b1, 8'h0d, 1'b1, 1'b0);
		@(negedge core_clk_in);
		set_exc(cause_bad_opcode, 1'b0, 1'b0);
		exc_in.executing = 1'b0;
		@(negedge core_clk_in);
		exc_in.valid = 1'b0;
		wait_dsp(4);
		chk(dsp.valid, 1'b0);
		$display("t_table done");
	endtask : t_table

	// handler entry finished, next pending one taken before it runs
	task nxt(input logic [7:0] ev);
		done_pulse;
		wait_dsp(8);
		chk(dsp.vector, ev);
		chk(dsp.push_code, 1'b0);
		chk(dsp.ext, 1'b1);
		chk(ack, ev == 8'h40);
		if (ev == 8'h09)
			chk(dsp.restartable, 1'b0);
	endtask : nxt

	task t_order;
		@(negedge core_clk_in);
		set_exc(cause_divide, 1'b0, 1'b0);
		@(negedge core_clk_in);
		exc_in.valid = 1'b0;
		step_in = 1'b1;
		nmi_cmd = 1'b1;
		irq_cmd = 1'b1;
		ien = 1'b1;
		xfer = '{1'b1, 1'b1, 16'h0101, 16'h0100};
		@(negedge core_clk_in);
		step_in = 1'b0;
		nmi_cmd = 1'b0;
		xfer.valid = 1'b0;
		repeat (6) @(negedge core_clk_in);
		nxt(8'h01);
		nxt(8'h02);
		nxt(8'h09);
		nxt(8'h40);
		irq_cmd = 1'b0;
		ien = 1'b0;
		done_pulse;
		$display("t_order done");
	endtask : t_order

	task t_benign;
		@(negedge core_clk_in);
		set_exc(cause_bad_opcode, 1'b0, 1'b0);
		@(negedge core_clk_in);
		exc_in.cause = cause_stack;
		@(negedge core_clk_in);
		exc_in.valid = 1'b0;
		chk(dsp.vector, 8'h0c);
		done_pulse;
		$display("t_benign done");
	endtask : t_benign

	task cop_try(input logic lw, input logic [15:0] off, input logic hit);
		@(negedge core_clk_in);
		xfer = '{1'b1, lw, off, 16'h0100};
		@(negedge core_clk_in);
		xfer.valid = 1'b0;
		wait_dsp(4);
		// after an overrun the bench issues no coprocessor waits before the next transfer
		chk(dsp.valid, hit);
		if (hit)
			done_pulse;
	endtask : cop_try

	// fault, double fault, then shutdown with one halt cycle
	task enter_shut;
		@(negedge core_clk_in);
		set_exc(cause_general, 1'b1, 1'b0);
		@(negedge core_clk_in);
		chk(dsp.vector, 8'h0d);
		exc_in.cause = cause_stack;
		@(negedge core_clk_in);
		chk({dsp.vector, dsp.push_code, dsp.code, dsp.restartable}, {8'h08, 1'b1, 16'h0, 1'b0});
		exc_in.cause = cause_general;
		@(negedge core_clk_in);
		exc_in.valid = 1'b0;
		chk({halt, abo, shut}, 3'b101);
		@(negedge core_clk_in);
		chk({halt, abo, shut}, 3'b011);
	endtask : enter_shut

	task t_shut;
		@(negedge core_clk_in);
		pen = 1'b1;
		@(negedge core_clk_in);
		pen = 1'b0;
		enter_shut;
		@(negedge core_clk_in);
		exc_in.valid = 1'b1;
		@(negedge core_clk_in);
		exc_in.valid = 1'b0;
		wait_dsp(4);
		chk({dsp.valid, halt, shut}, 3'b001);
		nmi_cmd = 1'b1;
		@(negedge core_clk_in);
		nmi_cmd = 1'b0;
		wait_dsp(10);
		chk(dsp.vector, 8'h02);
		done_pulse;
		@(negedge core_clk_in);
		chk({shut, prot}, 2'b01);
		enter_shut;
		nmi_cmd = 1'b1;
		@(negedge core_clk_in);
		nmi_cmd = 1'b0;
		wait_dsp(10);
		exc_in.valid = 1'b1;
		@(negedge core_clk_in);
		exc_in.valid = 1'b0;
		chk({halt, abo, shut}, 3'b101);
		rst_in = 1'b1;
		repeat (2) @(negedge core_clk_in);
		rst_in = 1'b0;
		chk({shut, prot, abo}, 3'b001);
		$display("t_shut done");
	endtask : t_shut

	// watchdog well beyond the 150 or so cycles the tests need
	initial begin
		#40000;
		failures++;
		print_verdict;
	end

	// main sequence
	initial begin
		exc_in = '0;
		exc_in.selector = 16'hbeef;
		exc_in.local_descriptor_table = 1'b1;
		exc_in.prefix_addr = 16'h1230;
		repeat (10) @(negedge core_clk_in);
		rst_in = 1'b0;
		chk({dsp.valid, ack, halt, abo, shut, prot}, 6'b000100);
		t_table;
		t_order;
		t_benign;
		cop_try(1'b0, 16'h0200, 1'b0);
		cop_try(1'b1, 16'h0100, 1'b0);
		cop_try(1'b1, 16'h0101, 1'b1);
		t_shut;
		print_verdict;
	end
endmodule : tb_exception_sequencer
